//--- common/svm_pkg.sv
// package for the two-channel supply-voltage monitor control block
// assumes a 32-bit apb register bus and one 20 mhz gear clock
package svm_pkg;

  // ***********************************************************
  // channel count, bus widths and clock
  // ***********************************************************
  localparam int          NUM_CH        = 2;
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  localparam int          LVL_W         = 2;
  localparam int          CLK_PERIOD_NS = 50;

  // ***********************************************************
  // register byte offsets
  // ***********************************************************
  localparam logic [11:0] ADDR_LEVEL_FLAGS = 12'h000;
  localparam logic [11:0] ADDR_CONTROL     = 12'h004;

  // ***********************************************************
  // level and flags register layout, one nibble per channel
  // ***********************************************************
  localparam int          LF_STRIDE  = 4;
  localparam int          LF_LVL_OFS = 0;
  localparam int          LF_SF_OFS  = 2;
  localparam int          LF_F_OFS   = 3;
  localparam int          LF_WIDTH   = 8;

  // ***********************************************************
  // control register layout, two bits per channel plus spare pair
  // ***********************************************************
  localparam int          CT_STRIDE    = 2;
  localparam int          CT_EN_OFS    = 0;
  localparam int          CT_ACT_OFS   = 1;
  localparam int          CT_SPARE_LSB = 4;
  localparam int          CT_SPARE_W   = 2;
  localparam int          CT_WIDTH     = 8;

  // ***********************************************************
  // reset values
  // ***********************************************************
  localparam logic [1:0]  LVL_RESET_CH1   = 2'h0;
  localparam logic [1:0]  LVL_RESET_CH2   = 2'h2;
  localparam logic [1:0]  SPARE_RESET     = 2'h0;
  localparam logic        ACT_IRQ         = 1'h0;
  localparam logic        ACT_RESET       = 1'h1;

  // ***********************************************************
  // software settle time after enabling a channel
  // ***********************************************************
  localparam int          SETTLE_TIME_NS  = 5000;
  localparam int          SETTLE_CYCLES   = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // per channel configuration: action and enable held in the control register, level in the level and flags register
  typedef struct packed {
    logic             act;
    logic             en;
    logic [LVL_W-1:0] lvl;
  } chan_ctl_t;

  // power mode tracking states
  typedef enum logic [2:0] {
    ST_RUN     = 3'h1,
    ST_HOLD    = 3'h2,
    ST_RELEASE = 3'h4
  } pm_state_t;

endpackage : svm_pkg

//--- core/supply_voltage_monitor_ctrl.sv
// control logic of a two-channel supply-voltage monitor with apb registers
// assumes rst_i is the power-on or external reset, comparators are asynchronous,
// and the low-power mode inputs are synchronous to clk_i
//
// Notes on behaviour
// [R1] action bit picks interrupt or reset
// [R2] enabled interrupt action raises irq on undervolt
// [R3] crossings both ways raise irq, unfiltered
// [R4] low-power undervolt irq waits for mode exit
// [R5] reset request held while supply below threshold
// [R6] only power-on/external reset initialises registers
// [R7] latched flag sets, survives supply recovery
// [R8] latched flag cleared only by writing 0
// [R9] live status follows comparator, no memory
// [R10] low-power flag updates wait for mode exit
// [R11] live status leads latched flag by <=2 cycles
// [R12] two independent channels with own fields
// [R13] software interrupt setup sequence with 5 us wait
// [R14] software masks irq before disabling channel
// [R15] software clears flag before choosing reset action
// [R16] retained enable re-asserts reset immediately
// [R17] software disable sequence for reset action
// [R18] detection beats simultaneous software clear
// [R19] enabling while below raises request at once
// [R20] comparators pass two-flop synchroniser first
`timescale 1ns/1ps

module supply_voltage_monitor_ctrl #(
  parameter int NUM_CH = svm_pkg::NUM_CH
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [svm_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [svm_pkg::DATA_W-1:0] pwdata_i,
  input  wire logic [3:0]                pstrb_i,
  output logic                           pready_o,
  output logic [svm_pkg::DATA_W-1:0]     prdata_o,
  output logic                           pslverr_o,
  input  wire logic [NUM_CH-1:0]         comp_below_i,
  input  wire logic                      deep_halt_i,
  input  wire logic                      idle_zero_mode_i,
  input  wire logic                      sleep_zero_mode_i,
  output logic [NUM_CH-1:0]              comp_enable_o,
  output logic [NUM_CH*svm_pkg::LVL_W-1:0] threshold_sel_o,
  output logic                           undervolt_irq_o,
  output logic                           vd_reset_req_o
);

  // ***********************************************************
  // declarations
  // ***********************************************************
  svm_pkg::chan_ctl_t                 ctl_r [NUM_CH];
  logic [svm_pkg::CT_SPARE_W-1:0]     spare_r;
  logic [NUM_CH-1:0]                  sync1_r;
  logic [NUM_CH-1:0]                  below_r;
  logic [NUM_CH-1:0]                  below_prev_r;
  logic [NUM_CH-1:0]                  irq_cond_prev_r;
  logic [NUM_CH-1:0]                  latched_r;
  logic [NUM_CH-1:0]                  status_r;
  logic [NUM_CH-1:0]                  pending_r;
  logic                               pready_r;
  logic [svm_pkg::DATA_W-1:0]         prdata_r;
  logic                               pslverr_r;
  logic                               irq_r;
  logic                               reset_req_r;
  svm_pkg::pm_state_t                 state_r;
  svm_pkg::pm_state_t                 state_nxt;
  logic                               low_power;
  logic                               access;
  logic                               wr_level;
  logic                               wr_ctrl;
  logic [NUM_CH-1:0]                  en_vec;
  logic [NUM_CH-1:0]                  act_vec;
  logic [NUM_CH-1:0]                  detect;
  logic [NUM_CH-1:0]                  irq_cond;
  logic [NUM_CH-1:0]                  irq_edge;
  logic [svm_pkg::LF_WIDTH-1:0]       level_rd;
  logic [svm_pkg::CT_WIDTH-1:0]       ctrl_rd;

  // ***********************************************************
  // address decode helper
  // ***********************************************************
  // true when the bus address hits the given register word
  function automatic logic addr_hit(input logic [svm_pkg::ADDR_W-1:0] addr,
                                    input logic [svm_pkg::ADDR_W-1:0] reg_addr);
    addr_hit = (addr == reg_addr);
  endfunction : addr_hit

  // ***********************************************************
  // comparator synchroniser
  // ***********************************************************
  // [R20] two flop synchroniser
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_r <= '0;
      below_r <= '0;
    end
    else
    begin
      sync1_r <= comp_below_i;
      below_r <= sync1_r;
    end
  end

  // ***********************************************************
  // apb slave
  // ***********************************************************
  // access phase is the cycle in which pready is high
  assign access   = psel_i & penable_i & pready_r;
  assign wr_level = access & pwrite_i & pstrb_i[0] & addr_hit(paddr_i, svm_pkg::ADDR_LEVEL_FLAGS);
  assign wr_ctrl  = access & pwrite_i & pstrb_i[0] & addr_hit(paddr_i, svm_pkg::ADDR_CONTROL);

  // read images of both registers, unused bits read zero
  always_comb
  begin
    level_rd = '0;
    ctrl_rd  = '0;
    for (int c = 0; c < NUM_CH; c++)
    begin
      level_rd[c*svm_pkg::LF_STRIDE+svm_pkg::LF_LVL_OFS +: svm_pkg::LVL_W] = ctl_r[c].lvl;
      level_rd[c*svm_pkg::LF_STRIDE+svm_pkg::LF_SF_OFS]                    = status_r[c];
      level_rd[c*svm_pkg::LF_STRIDE+svm_pkg::LF_F_OFS]                     = latched_r[c];
      ctrl_rd[c*svm_pkg::CT_STRIDE+svm_pkg::CT_EN_OFS]                     = ctl_r[c].en;
      ctrl_rd[c*svm_pkg::CT_STRIDE+svm_pkg::CT_ACT_OFS]                    = ctl_r[c].act;
    end
    ctrl_rd[svm_pkg::CT_SPARE_LSB +: svm_pkg::CT_SPARE_W] = spare_r;
  end

  // one wait-free answer: pready rises in the access phase after setup
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pready_r  <= 1'b0;
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end
    else if (psel_i && !penable_i && !pready_r)
    begin
      pready_r  <= 1'b1;
      pslverr_r <= ~(addr_hit(paddr_i, svm_pkg::ADDR_LEVEL_FLAGS) |
                     addr_hit(paddr_i, svm_pkg::ADDR_CONTROL));
      if (addr_hit(paddr_i, svm_pkg::ADDR_LEVEL_FLAGS))
        prdata_r <= {{(svm_pkg::DATA_W-svm_pkg::LF_WIDTH){1'b0}}, level_rd};
      else if (addr_hit(paddr_i, svm_pkg::ADDR_CONTROL))
        prdata_r <= {{(svm_pkg::DATA_W-svm_pkg::CT_WIDTH){1'b0}}, ctrl_rd};
      else
        prdata_r <= '0;
    end
    else
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // ***********************************************************
  // configuration registers
  // ***********************************************************
  // [R6] initialised by block reset only
  // [R12] per channel fields
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        ctl_r[c].act <= svm_pkg::ACT_IRQ;
        ctl_r[c].en  <= 1'b0;
        ctl_r[c].lvl <= (c == 1) ? svm_pkg::LVL_RESET_CH2 : svm_pkg::LVL_RESET_CH1;
      end
      spare_r <= svm_pkg::SPARE_RESET;
    end
    else
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (wr_level)
          ctl_r[c].lvl <= pwdata_i[c*svm_pkg::LF_STRIDE+svm_pkg::LF_LVL_OFS +: svm_pkg::LVL_W];
        if (wr_ctrl)
        begin
          ctl_r[c].en  <= pwdata_i[c*svm_pkg::CT_STRIDE+svm_pkg::CT_EN_OFS];
          ctl_r[c].act <= pwdata_i[c*svm_pkg::CT_STRIDE+svm_pkg::CT_ACT_OFS];
        end
      end
      if (wr_ctrl)
        spare_r <= pwdata_i[svm_pkg::CT_SPARE_LSB +: svm_pkg::CT_SPARE_W];
    end
  end

  // ***********************************************************
  // detection terms
  // ***********************************************************
  // [R1] action select splits irq and reset
  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      en_vec[c]  = ctl_r[c].en;
      act_vec[c] = ctl_r[c].act;
    end
  end

  assign detect   = below_r & en_vec;
  assign irq_cond = detect & ~act_vec;

  // [R3] both crossings in interrupt action
  // [R19] enabling while below counts as edge
  assign irq_edge = (irq_cond & ~irq_cond_prev_r) |
                    (en_vec & ~act_vec & ~below_r & below_prev_r);

  // ***********************************************************
  // low-power mode tracking
  // ***********************************************************
  assign low_power = deep_halt_i | idle_zero_mode_i | sleep_zero_mode_i;

  // next state: hold while in a deep mode, one release cycle on exit
  always_comb
  begin
    case (state_r)
      svm_pkg::ST_RUN:     state_nxt = low_power ? svm_pkg::ST_HOLD : svm_pkg::ST_RUN;
      svm_pkg::ST_HOLD:    state_nxt = low_power ? svm_pkg::ST_HOLD : svm_pkg::ST_RELEASE;
      svm_pkg::ST_RELEASE: state_nxt = low_power ? svm_pkg::ST_HOLD : svm_pkg::ST_RUN;
      default:             state_nxt = svm_pkg::ST_RUN;
    endcase
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_r <= svm_pkg::ST_RUN;
    else
      state_r <= state_nxt;
  end

  // ***********************************************************
  // flags and pending detections
  // ***********************************************************
  // [R10] deferred while in deep modes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pending_r <= '0;
    else if (state_r == svm_pkg::ST_HOLD)
      pending_r <= pending_r | detect;
    else
      pending_r <= '0;
  end

  // [R9] live status tracks comparator
  // [R11] status and flag update together
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      status_r <= '0;
    else if (state_r != svm_pkg::ST_HOLD)
      status_r <= detect;
  end

  // [R7] sticky undervolt flag
  // [R8] cleared only by writing zero
  // [R18] detection wins over clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      latched_r <= '0;
    else
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (state_r == svm_pkg::ST_RUN && detect[c])
          latched_r[c] <= 1'b1;
        else if (state_r == svm_pkg::ST_RELEASE && (detect[c] || pending_r[c]))
          latched_r[c] <= 1'b1;
        else if (wr_level && !pwdata_i[c*svm_pkg::LF_STRIDE+svm_pkg::LF_F_OFS])
          latched_r[c] <= 1'b0;
      end
    end
  end

  // ***********************************************************
  // interrupt request
  // ***********************************************************
  // edge history only advances outside deep modes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      below_prev_r    <= '0;
      irq_cond_prev_r <= '0;
    end
    else if (state_r != svm_pkg::ST_HOLD)
    begin
      below_prev_r    <= below_r;
      irq_cond_prev_r <= irq_cond;
    end
  end

  // [R2] irq pulse on undervolt
  // [R4] deferred irq after mode exit
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_r <= 1'b0;
    else if (state_r == svm_pkg::ST_RUN)
      irq_r <= |irq_edge;
    else if (state_r == svm_pkg::ST_RELEASE)
      irq_r <= |(irq_edge | (pending_r & en_vec & ~act_vec));
    else
      irq_r <= 1'b0;
  end

  // ***********************************************************
  // voltage detection reset request
  // ***********************************************************
  // [R5] held while supply below
  // [R16] retained enable re-asserts at once
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      reset_req_r <= 1'b0;
    else
      reset_req_r <= |(detect & act_vec);
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  assign pready_o        = pready_r;
  assign prdata_o        = prdata_r;
  assign pslverr_o       = pslverr_r;
  assign undervolt_irq_o = irq_r;
  assign vd_reset_req_o  = reset_req_r;

  // analogue side controls taken from the configuration flops
  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      comp_enable_o[c]                                   = ctl_r[c].en;
      threshold_sel_o[c*svm_pkg::LVL_W +: svm_pkg::LVL_W] = ctl_r[c].lvl;
    end
  end

endmodule : supply_voltage_monitor_ctrl

//--- verification/supply_comp_model.sv
// stand-in for the two analogue under-voltage comparators
// assumes the bench names the wanted supply condition per channel
`timescale 1ns/1ps
module supply_comp_model (
  input  wire logic       clk_i,
  input  wire logic [1:0] below_i,
  input  wire logic       chatter_i,
  output logic      [1:0] comp_below_o
);
  integer seed = 32'hf208;

  initial comp_below_o = 2'h0;
  // chatter near threshold
  // outputs move just after the rising edge, like every other bench input
  always @(posedge clk_i)
    comp_below_o <= chatter_i ? 2'($random(seed)) : below_i;
endmodule : supply_comp_model

//--- verification/svm_chk_sva.sv
// checker for the supply monitor control block
// assumes it is bound onto the top module ports
`timescale 1ns/1ps
module svm_chk #(
  parameter int NUM_CH = 2
) (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                psel_i,
  input wire logic                penable_i,
  input wire logic                pwrite_i,
  input wire logic                pready_o,
  input wire logic [31:0]         prdata_o,
  input wire logic                pslverr_o,
  input wire logic [NUM_CH-1:0]   comp_below_i,
  input wire logic                deep_halt_i,
  input wire logic                idle_zero_mode_i,
  input wire logic                sleep_zero_mode_i,
  input wire logic [NUM_CH-1:0]   comp_enable_o,
  input wire logic [2*NUM_CH-1:0] threshold_sel_o,
  input wire logic                undervolt_irq_o,
  input wire logic                vd_reset_req_o
);
  logic                lp;
  logic                wr_q;
  logic                rst_q;
  logic [3*NUM_CH-1:0] cfg_q;

  // any deep low-power mode
  assign lp = deep_halt_i | idle_zero_mode_i | sleep_zero_mode_i;

  // last write strobe, reset and configuration
  always_ff @(posedge clk_i)
  begin
    wr_q  <= psel_i & penable_i & pwrite_i & pready_o;
    rst_q <= rst_i;
    cfg_q <= {threshold_sel_o, comp_enable_o};
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ***********************************************************
  // assertions
  // ***********************************************************
  AST_RST_VALUES: assert property (
    $fell(rst_i) |-> !vd_reset_req_o && !undervolt_irq_o && comp_enable_o == '0
      && threshold_sel_o == {svm_pkg::LVL_RESET_CH2, svm_pkg::LVL_RESET_CH1})
    else $error("wrong values after reset");
  AST_CFG_BY_WRITE: assert property (
    !rst_q && {threshold_sel_o, comp_enable_o} != cfg_q |-> wr_q)
    else $error("config changed without a write");
  AST_PREADY_PULSE: assert property (
    psel_i && !penable_i && !pready_o |=> pready_o ##1 !pready_o)
    else $error("ready not one cycle after setup");
  AST_ERR_DATA: assert property (
    pready_o && pslverr_o |-> prdata_o == '0)
    else $error("error response with data");
  AST_IRQ_EN: assert property (
    undervolt_irq_o |-> $past(comp_enable_o) != '0)
    else $error("interrupt from disabled channel");
  AST_IRQ_LP: assert property (
    lp && $past(lp) && $past(lp, 2) |-> !undervolt_irq_o)
    else $error("interrupt during low power");
  AST_RST_HOLD: assert property (
    vd_reset_req_o && $past(comp_below_i, 2) == $past(comp_below_i, 3)
      && !wr_q |=> vd_reset_req_o)
    else $error("reset request dropped while below");
  AST_RST_CAUSE: assert property (
    vd_reset_req_o |-> $past(comp_below_i, 3) != '0 && $past(comp_enable_o) != '0)
    else $error("reset request without synced cause");

  cover property (undervolt_irq_o);
  cover property ($rose(vd_reset_req_o));
  cover property (pready_o && pslverr_o);
endmodule : svm_chk

bind supply_voltage_monitor_ctrl svm_chk #(.NUM_CH(NUM_CH)) u_chk (
  .clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .pready_o, .prdata_o, .pslverr_o,
  .comp_below_i, .deep_halt_i, .idle_zero_mode_i, .sleep_zero_mode_i,
  .comp_enable_o, .threshold_sel_o, .undervolt_irq_o, .vd_reset_req_o);

//--- verification/tb_supply_voltage_monitor_ctrl.sv
// self-checking bench for the supply monitor control block
// assumes the checker binds itself and the comparator model stands in
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_supply_voltage_monitor_ctrl;
  localparam logic [11:0] LF = svm_pkg::ADDR_LEVEL_FLAGS;
  localparam logic [11:0] CT = svm_pkg::ADDR_CONTROL;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h0;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0]  pstrb_i = 4'hf;
  logic [2:0]  lp = 3'h0;
  logic [1:0]  below = 2'h0;
  logic        chatter = 1'b0;
  wire  [1:0]  comp;
  wire         pready_o;
  wire         pslverr_o;
  wire         irq;
  wire         rreq;
  wire  [31:0] prdata_o;
  wire  [1:0]  cen;
  wire  [3:0]  thr;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          irq_cnt = 0;
  integer      seed = 32'hf208;
  logic [3:0]  lvl = 4'h8;
  logic [32:0] notes[$];

  supply_voltage_monitor_ctrl DUT (
    .clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
    .pready_o, .prdata_o, .pslverr_o, .comp_below_i(comp), .deep_halt_i(lp[0]),
    .idle_zero_mode_i(lp[1]), .sleep_zero_mode_i(lp[2]), .comp_enable_o(cen),
    .threshold_sel_o(thr), .undervolt_irq_o(irq), .vd_reset_req_o(rreq));
  supply_comp_model u_comp (.clk_i, .below_i(below), .chatter_i(chatter), .comp_below_o(comp));

  initial forever #25 clk_i = ~clk_i;

  // read results against oldest note, interrupt pulse count
  always @(negedge clk_i)
  begin
    if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i)
    begin
      `CHK("prdata", notes[0], {pslverr_o, prdata_o})
      void'(notes.pop_front());
    end
    if (irq === 1'b1)
      irq_cnt++;
  end

  // hang guard
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      final_report();
    end
  end

  task automatic final_report();
    if (num_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // one apb transfer, held until ready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(negedge clk_i);
    while (pready_o !== 1'b1)
      @(negedge clk_i);
    @(posedge clk_i);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : xfer

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    notes.push_back(e);
    xfer(1'b0, a, 32'($random(seed)));
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'($random(seed)), d});
  endtask : wr

  // thresholds written, flags in c cleared
  task automatic setlf(input logic [1:0] c);
    wr(LF, {~c[1], 1'b0, lvl[3:2], ~c[0], 1'b0, lvl[1:0]});
  endtask : setlf

  function automatic logic [32:0] lf(input logic [1:0] s, input logic [1:0] f);
    return {25'h0, f[1], s[1], lvl[3:2], f[0], s[0], lvl[1:0]};
  endfunction : lf

  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(LF, lf(2'h0, 2'h0));
    rd(12'h008, {1'b1, 32'h0});
    pstrb_i <= 4'h0;
    wr(CT, 8'h05);
    pstrb_i <= 4'hf;
    rd(CT, 33'h0);
    for (int ch = 0; ch < 2; ch++)
    begin
      lvl = 4'($random(seed));
      setlf(2'h0);
      wr(CT, 8'h1 << (2 * ch));
      repeat (svm_pkg::SETTLE_CYCLES) @(posedge clk_i);
      `CHK("cen", 2'h1 << ch, cen)
      `CHK("thr", lvl, thr)
      rd(LF, lf(2'h0, 2'h0));
      irq_cnt = 0;
      below[ch] <= 1'b1;
      repeat (6) @(posedge clk_i);
      rd(LF, lf(2'h1 << ch, 2'h1 << ch));
      below[ch] <= 1'b0;
      repeat (6) @(posedge clk_i);
      `CHK("irq_cnt", 2, irq_cnt)
      rd(LF, lf(2'h0, 2'h1 << ch));
      wr(CT, 8'h00);
      rd(LF, lf(2'h0, 2'h1 << ch));
      setlf(2'h1 << ch);
      rd(LF, lf(2'h0, 2'h0));
    end
    wr(CT, 8'h01);
    for (int m = 0; m < 3; m++)
    begin
      lp[m] <= 1'b1;
      irq_cnt = 0;
      below[0] <= 1'b1;
      repeat (8) @(posedge clk_i);
      rd(LF, lf(2'h0, 2'h0));
      `CHK("lp_irq", 0, irq_cnt)
      lp[m] <= 1'b0;
      repeat (6) @(posedge clk_i);
      `CHK("wake_irq", 1, irq_cnt)
      rd(LF, lf(2'h1, 2'h1));
      setlf(2'h1);
      rd(LF, lf(2'h1, 2'h1));
      below[0] <= 1'b0;
      repeat (6) @(posedge clk_i);
      setlf(2'h1);
    end
    wr(CT, 8'h03);
    irq_cnt = 0;
    below[0] <= 1'b1;
    repeat (36) @(posedge clk_i);
    `CHK("rreq", 1'b1, rreq)
    rd(CT, 33'h3);
    below[0] <= 1'b0;
    repeat (6) @(posedge clk_i);
    `CHK("rreq_off", 1'b0, rreq)
    below[0] <= 1'b1;
    repeat (6) @(posedge clk_i);
    `CHK("rreq_again", 1'b1, rreq)
    `CHK("rst_irq", 0, irq_cnt)
    wr(CT, 8'h01);
    wr(CT, 8'h00);
    repeat (2) @(posedge clk_i);
    `CHK("rreq_dis", 1'b0, rreq)
    wr(CT, 8'h03);
    repeat (2) @(posedge clk_i);
    `CHK("en_rreq", 1'b1, rreq)
    wr(CT, 8'h01);
    wr(CT, 8'h00);
    irq_cnt = 0;
    wr(CT, 8'h01);
    repeat (3) @(posedge clk_i);
    `CHK("en_irq", 1, irq_cnt)
    below[0] <= 1'b0;
    chatter <= 1'b1;
    repeat (40) @(posedge clk_i);
    chatter <= 1'b0;
    repeat (6) @(posedge clk_i);
    `CHK("chatter", 1'b1, irq_cnt > 3)
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    lvl = 4'h8;
    rd(LF, lf(2'h0, 2'h0));
    rd(CT, 33'h0);
    `CHK("thr_rst", 4'h8, thr)
    `CHK("cen_rst", 2'h0, cen)
    repeat (4) @(posedge clk_i);
    final_report();
  end
endmodule : tb_supply_voltage_monitor_ctrl
